// ==== sim/test_ump_serial_port.sv ====
`timescale 1ns/1ps
module test_ump_serial_port;
	import ump_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	ump_sfr_t sfrReq = '0;
	logic [7:0] sfrRdData;
	logic serialRxPin;
	logic serialTxPin;
	logic irqRequest;
	int fails = 0;
	int checked = 0;
	always #5 clk = ~clk;
	ump_serial_port uut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
		.sfrReq(sfrReq), .sfrRdData(sfrRdData),
		.timerTick(1'b1), // Timer straight off system clock
		.baudTimerReloadByte(8'hfc), .serialRxPin(serialRxPin),
		.serialTxPin(serialTxPin), .irqRequest(irqRequest));
	ump_remote_node #(.BIT_CYC(8)) node (.clk(clk),
		.lineIn(serialTxPin), .lineOut(serialRxPin));
	task automatic close_out();
		$display("checks %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfrReq = '{a, d, 1'b1, 1'b0};
		@(negedge clk);
		sfrReq = '{a, d, 1'b0, 1'b0};
		// Let an edge pass so the next request never lands in this step
		@(negedge clk);
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		sfrReq = '{a, 8'h00, 1'b0, 1'b1};
		@(negedge clk);
		sfrReq = '{a, 8'h00, 1'b0, 1'b0};
		d = sfrRdData;
		@(negedge clk);
	endtask
	task automatic t_regs();
		logic [7:0] d;
		rd(UMP_ADDR_CTRL, d);
		check("ctrl reset", d, UMP_CTRL_RESET);
		wr(UMP_ADDR_CTRL, 8'hb8);
		rd(UMP_ADDR_CTRL, d);
		check("ctrl rw", d, 8'hf8);
		wr(8'h9a, 8'h00);
		rd(8'h9a, d);
		check("unmapped", d, 8'h00);
		wr(UMP_ADDR_CTRL, 8'h00);
		rd(UMP_ADDR_CTRL, d);
		check("bit6 kept", d, 8'h40);
	endtask
	task automatic t_tx(logic nine, logic tb8, logic [7:0] v);
		logic [10:0] f;
		logic ok;
		logic [7:0] d;
		wr(UMP_ADDR_CTRL, {nine, 3'b000, tb8, 3'b000});
		wr(UMP_ADDR_BUF, v);
		node.grab(nine, f, ok);
		if (!ok) begin
			fails++;
			close_out();
		end
		check("start", f[0], 1'b0);
		check("tx data", f[8:1], v);
		check("ninth", f[9], nine ? tb8 : 1'b1);
		check("stop", nine ? f[10] : f[9], 1'b1);
		check("irq tx", irqRequest, 1'b1);
		rd(UMP_ADDR_CTRL, d);
		check("tx flag", d[1], 1'b1);
		wr(UMP_ADDR_CTRL, 8'h00);
		check("irq clr", irqRequest, 1'b0);
	endtask
	task automatic t_rx(logic [7:0] c, logic [7:0] v, logic b9, logic stp,
		logic acc);
		logic [7:0] d;
		wr(UMP_ADDR_CTRL, c);
		node.send(v, c[7], b9, stp);
		repeat (8) @(negedge clk);
		check("irq rx", irqRequest, acc);
		rd(UMP_ADDR_CTRL, d);
		check("rx flag", d[0], acc);
		if (acc) begin
			check("rx bit2", d[2], c[7] ? b9 : stp);
			rd(UMP_ADDR_BUF, d);
			check("rx data", d, v);
			node.send(8'h11, c[7], 1'b1, 1'b1);
			repeat (8) @(negedge clk);
			rd(UMP_ADDR_BUF, d);
			check("overrun", d, v);
		end
		wr(UMP_ADDR_CTRL, 8'h00);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		t_regs();
		t_tx(1'b0, 1'b1, 8'ha5);
		t_tx(1'b1, 1'b1, 8'h3c);
		t_tx(1'b1, 1'b0, 8'hc3);
		t_rx(8'h10, 8'h5a, 1'b0, 1'b1, 1'b1);
		t_rx(8'h10, 8'h33, 1'b0, 1'b0, 1'b1);
		t_rx(8'h30, 8'h33, 1'b0, 1'b0, 1'b0);
		t_rx(8'h90, 8'h66, 1'b0, 1'b1, 1'b1);
		t_rx(8'hb0, 8'h66, 1'b0, 1'b1, 1'b0);
		t_rx(8'hb0, 8'h42, 1'b1, 1'b1, 1'b1);
		// Address matched: filter cleared to take the data frame
		t_rx(8'h90, 8'h24, 1'b0, 1'b1, 1'b1);
		t_rx(8'h80, 8'h5a, 1'b1, 1'b1, 1'b0);
		close_out();
	end
endmodule // test_ump_serial_port
bind ump_serial_port ump_serial_port_asserts chk (.clk(clk),
	.arst_n(arst_n), .ce(ce), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
	.timerTick(timerTick), .baudTimerReloadByte(baudTimerReloadByte),
	.serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
	.irqRequest(irqRequest));

// ==== sim/ump_remote_node.sv ====
`timescale 1ns/1ps
module ump_remote_node #(parameter int BIT_CYC = 8) (
	input wire logic clk,
	input wire logic lineIn,
	output logic lineOut
);
	initial lineOut = 1'b1;
	// Start low, data LSB first, optional ninth, stop
	task automatic send(input logic [7:0] d, input logic nine,
		input logic b9, input logic stp);
		logic [10:0] f;
		f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			lineOut = f[i];
			repeat (BIT_CYC) @(negedge clk);
		end
		lineOut = 1'b1; // Line pulled up when released
	endtask
	// Mid-bit sampling keeps clear of edge skew
	task automatic grab(input logic nine, output logic [10:0] f,
		output logic ok);
		int k;
		f = '1;
		k = 0;
		// First tx bit tick waits for the timer's long count out of reset
		while (lineIn && k < 600) begin
			@(negedge clk);
			k++;
		end
		ok = !lineIn;
		if (ok) begin
			repeat (BIT_CYC / 2) @(negedge clk);
			for (int i = 0; i < (nine ? 11 : 10); i++) begin
				f[i] = lineIn;
				repeat (BIT_CYC) @(negedge clk);
			end
		end
	endtask
endmodule // ump_remote_node

// ==== sim/ump_serial_port_asserts.sv ====
`timescale 1ns/1ps
module ump_serial_port_asserts
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire ump_sfr_t sfrReq,
	input wire logic [7:0] sfrRdData,
	input wire logic timerTick,
	input wire logic [7:0] baudTimerReloadByte,
	input wire logic serialRxPin,
	input wire logic serialTxPin,
	input wire logic irqRequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic rdCtl;
	logic rdOff;
	logic wrCtl;
	assign rdCtl = ce && sfrReq.rdEn && sfrReq.addr == UMP_ADDR_CTRL;
	assign wrCtl = ce && sfrReq.wrEn && sfrReq.addr == UMP_ADDR_CTRL;
	assign rdOff = ce && sfrReq.rdEn && sfrReq.addr != UMP_ADDR_CTRL
		&& sfrReq.addr != UMP_ADDR_BUF;
	chk_bit6_one: assert property (rdCtl |=> sfrRdData[UMP_BIT_ONE])
		else $error("control bit 6 read as zero");
	chk_flags_irq: assert property (rdCtl |=>
		(|sfrRdData[1:0]) == $past(irqRequest)) else $error("flags vs irq");
	chk_unmapped_zero: assert property (rdOff |=> sfrRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_rd_hold: assert property (!(ce && sfrReq.rdEn) |=> $stable(sfrRdData))
		else $error("read data moved without read");
	chk_irq_sticky: assert property (irqRequest && !wrCtl |=> irqRequest)
		else $error("done flag cleared by hardware");
	chk_reset_idle: assert property ($rose(arst_n) |->
		serialTxPin && !irqRequest) else $error("bad state after reset");
	chk_start_len: assert property ($fell(serialTxPin) && ce && timerTick
		&& baudTimerReloadByte == 8'hfc |-> !serialTxPin [*8])
		else $error("start bit too short");
	chk_ti_at_stop: assert property ($rose(irqRequest) |-> serialTxPin)
		else $error("done flag rose with line low");
	cover property (rdOff);
	cover property ($rose(irqRequest));
	cover property ($fell(serialTxPin));
endmodule // ump_serial_port_asserts

// ==== src/ump_baud_timer.sv ====
`timescale 1ns/1ps
module ump_baud_timer
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic timerTick,
	input wire logic [7:0] reloadByte,
	input wire logic forceReload,
	output logic overflow,
	output logic bitTick
);
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	logic half_ff;
	logic nxt_half;

	assign overflow = timerTick && (count_ff == UMP_TIMER_TOP) && !forceReload;
	// Two overflows make one bit time
	assign bitTick = overflow && half_ff;

	always_comb begin
		nxt_count = count_ff;
		nxt_half = half_ff;
		if (forceReload) begin
			nxt_count = reloadByte;
			nxt_half = 1'b0;
		end else if (overflow) begin
			nxt_count = reloadByte;
			nxt_half = !half_ff;
		end else if (timerTick) begin
			nxt_count = count_ff + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= 8'h00;
			half_ff <= 1'b0;
		end else if (ce) begin
			count_ff <= nxt_count;
			half_ff <= nxt_half;
		end
	end
endmodule // ump_baud_timer

// ==== src/ump_pkg.sv ====
package ump_pkg;
	localparam logic [7:0] UMP_ADDR_CTRL = 8'h98;
	localparam logic [7:0] UMP_ADDR_BUF = 8'h99;
	localparam logic [7:0] UMP_CTRL_RESET = 8'h40;
	localparam int UMP_BIT_MODE = 7;
	localparam int UMP_BIT_ONE = 6;
	localparam int UMP_BIT_MCE = 5;
	localparam int UMP_BIT_REN = 4;
	localparam int UMP_BIT_TB8 = 3;
	localparam int UMP_BIT_RB8 = 2;
	localparam int UMP_BIT_TI = 1;
	localparam int UMP_BIT_RI = 0;
	localparam logic [3:0] UMP_DATA_BITS = 4'h8;
	localparam logic [3:0] UMP_LAST_BIT = 4'h7;
	localparam logic [7:0] UMP_TIMER_TOP = 8'hff;
	localparam logic UMP_LINE_IDLE = 1'b1;
	localparam logic UMP_START_LEVEL = 1'b0;

	typedef struct packed {
		logic frameModeSelect;
		logic multiprocFilterEnable;
		logic receiverEnable;
		logic txNinthBit;
		logic rxNinthBit;
		logic txDoneFlag;
		logic rxDoneFlag;
	} ump_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrEn;
		logic rdEn;
	} ump_sfr_t;

	typedef enum logic [4:0] {
		UMP_S_IDLE = 5'h01,
		UMP_S_START = 5'h02,
		UMP_S_DATA = 5'h04,
		UMP_S_NINTH = 5'h08,
		UMP_S_STOP = 5'h10
	} ump_state_t;
endpackage

// ==== src/ump_serial_port.sv ====
`timescale 1ns/1ps
module ump_serial_port
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire ump_sfr_t sfrReq,
	output logic [7:0] sfrRdData,
	input wire logic timerTick,
	input wire logic [7:0] baudTimerReloadByte,
	input wire logic serialRxPin,
	output logic serialTxPin,
	output logic irqRequest
);
	ump_ctrl_t ctrl_ff, nxt_ctrl;
	ump_state_t txState_ff, nxt_txState;
	ump_state_t rxState_ff, nxt_rxState;
	logic [7:0] txShift_ff, nxt_txShift;
	logic [3:0] txCount_ff, nxt_txCount;
	logic txPin_ff, nxt_txPin;
	logic [7:0] rxShift_ff, nxt_rxShift;
	logic [3:0] rxCount_ff, nxt_rxCount;
	logic rxNinth_ff, nxt_rxNinth;
	logic [7:0] rxLatch_ff, nxt_rxLatch;
	logic rxPrev_ff;
	logic [7:0] rdData_ff, nxt_rdData;
	logic wrCtrl, wrBuf, rdCtrl, rdBuf;
	logic txTick, rxOvf, rxBitTick, startEdge, rxSample;
	logic txDoneSet, rxAccept, rxFilterPass, rxStoreBit;
	logic [7:0] ctrlView;

	assign wrCtrl = sfrReq.wrEn && (sfrReq.addr == UMP_ADDR_CTRL);
	assign wrBuf = sfrReq.wrEn && (sfrReq.addr == UMP_ADDR_BUF);
	assign rdCtrl = sfrReq.rdEn && (sfrReq.addr == UMP_ADDR_CTRL);
	assign rdBuf = sfrReq.rdEn && (sfrReq.addr == UMP_ADDR_BUF);

	// Stand-in for the user-invisible copy of the baud timer
	ump_baud_timer txTimer (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.timerTick(timerTick),
		.reloadByte(baudTimerReloadByte),
		.forceReload(1'b0),
		.overflow(),
		.bitTick(txTick)
	);

	ump_baud_timer rxTimer (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.timerTick(timerTick),
		.reloadByte(baudTimerReloadByte),
		.forceReload(startEdge),
		.overflow(rxOvf),
		.bitTick(rxBitTick)
	);

	// Reload on the edge puts the first overflow mid start bit
	assign startEdge = (rxState_ff == UMP_S_IDLE) && ctrl_ff.receiverEnable
		&& (rxPrev_ff == UMP_LINE_IDLE)
		&& (serialRxPin == UMP_START_LEVEL);
	assign rxSample = rxOvf && !rxBitTick;

	always_comb begin
		ctrlView = '0;
		ctrlView[UMP_BIT_MODE] = ctrl_ff.frameModeSelect;
		ctrlView[UMP_BIT_ONE] = 1'b1;
		ctrlView[UMP_BIT_MCE] = ctrl_ff.multiprocFilterEnable;
		ctrlView[UMP_BIT_REN] = ctrl_ff.receiverEnable;
		ctrlView[UMP_BIT_TB8] = ctrl_ff.txNinthBit;
		ctrlView[UMP_BIT_RB8] = ctrl_ff.rxNinthBit;
		ctrlView[UMP_BIT_TI] = ctrl_ff.txDoneFlag;
		ctrlView[UMP_BIT_RI] = ctrl_ff.rxDoneFlag;
	end

	// Transmitter
	always_comb begin
		nxt_txState = txState_ff;
		nxt_txShift = txShift_ff;
		nxt_txCount = txCount_ff;
		nxt_txPin = txPin_ff;
		txDoneSet = 1'b0;
		if (wrBuf) begin
			nxt_txShift = sfrReq.wrData;
			nxt_txState = UMP_S_START;
			nxt_txCount = '0;
		end else if (txTick) begin
			case (txState_ff)
				UMP_S_IDLE: begin
					nxt_txPin = UMP_LINE_IDLE;
				end
				UMP_S_START: begin
					nxt_txPin = UMP_START_LEVEL;
					nxt_txState = UMP_S_DATA;
				end
				UMP_S_DATA: begin
					nxt_txPin = txShift_ff[0];
					nxt_txShift = {1'b0, txShift_ff[7:1]};
					nxt_txCount = txCount_ff + 4'h1;
					if (txCount_ff == UMP_LAST_BIT) begin
						nxt_txState = ctrl_ff.frameModeSelect ? UMP_S_NINTH
							: UMP_S_STOP;
					end
				end
				UMP_S_NINTH: begin
					nxt_txPin = ctrl_ff.txNinthBit;
					nxt_txState = UMP_S_STOP;
				end
				UMP_S_STOP: begin
					nxt_txPin = UMP_LINE_IDLE;
					txDoneSet = 1'b1;
					nxt_txState = UMP_S_IDLE;
				end
				default: begin
					nxt_txState = UMP_S_IDLE;
				end
			endcase
		end
	end

	// Receiver
	always_comb begin
		nxt_rxState = rxState_ff;
		nxt_rxShift = rxShift_ff;
		nxt_rxCount = rxCount_ff;
		nxt_rxNinth = rxNinth_ff;
		nxt_rxLatch = rxLatch_ff;
		rxAccept = 1'b0;
		rxFilterPass = 1'b1;
		rxStoreBit = rxNinth_ff;
		if (ctrl_ff.frameModeSelect) begin
			// Stop level plays no part in 9-bit mode
			rxFilterPass = !ctrl_ff.multiprocFilterEnable
				|| rxNinth_ff;
		end else begin
			rxStoreBit = serialRxPin;
			rxFilterPass = !ctrl_ff.multiprocFilterEnable
				|| serialRxPin;
		end
		if (startEdge) begin
			nxt_rxState = UMP_S_START;
			nxt_rxCount = '0;
		end else if (rxSample) begin
			case (rxState_ff)
				UMP_S_IDLE: begin
					nxt_rxState = UMP_S_IDLE;
				end
				UMP_S_START: begin
					// A glitch shorter than half a bit is dropped
					nxt_rxState = (serialRxPin == UMP_START_LEVEL)
						? UMP_S_DATA : UMP_S_IDLE;
				end
				UMP_S_DATA: begin
					nxt_rxShift = {serialRxPin, rxShift_ff[7:1]};
					nxt_rxCount = rxCount_ff + 4'h1;
					if (rxCount_ff == UMP_LAST_BIT) begin
						nxt_rxState = ctrl_ff.frameModeSelect ? UMP_S_NINTH
							: UMP_S_STOP;
					end
				end
				UMP_S_NINTH: begin
					nxt_rxNinth = serialRxPin;
					nxt_rxState = UMP_S_STOP;
				end
				UMP_S_STOP: begin
					nxt_rxState = UMP_S_IDLE;
					// Overrun keeps the earlier byte
					if (!ctrl_ff.rxDoneFlag && rxFilterPass) begin
						rxAccept = 1'b1;
						nxt_rxLatch = rxShift_ff;
					end
				end
				default: begin
					nxt_rxState = UMP_S_IDLE;
				end
			endcase
		end
	end

	// Control register; hardware set wins over a software clear
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_rdData = rdData_ff;
		if (wrCtrl) begin
			nxt_ctrl.frameModeSelect = sfrReq.wrData[UMP_BIT_MODE];
			nxt_ctrl.multiprocFilterEnable = sfrReq.wrData[UMP_BIT_MCE];
			nxt_ctrl.receiverEnable = sfrReq.wrData[UMP_BIT_REN];
			nxt_ctrl.txNinthBit = sfrReq.wrData[UMP_BIT_TB8];
			nxt_ctrl.rxNinthBit = sfrReq.wrData[UMP_BIT_RB8];
			nxt_ctrl.txDoneFlag = sfrReq.wrData[UMP_BIT_TI];
			nxt_ctrl.rxDoneFlag = sfrReq.wrData[UMP_BIT_RI];
		end
		if (txDoneSet) begin
			nxt_ctrl.txDoneFlag = 1'b1;
		end
		if (rxAccept) begin
			nxt_ctrl.rxDoneFlag = 1'b1;
			nxt_ctrl.rxNinthBit = rxStoreBit;
		end
		if (rdCtrl) begin
			nxt_rdData = ctrlView;
		end else if (rdBuf) begin
			nxt_rdData = rxLatch_ff;
		end else if (sfrReq.rdEn) begin
			nxt_rdData = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// Bit 6 has no flop behind it, so skip it in the reset word
			ctrl_ff <= ump_ctrl_t'({UMP_CTRL_RESET[UMP_BIT_MODE],
				UMP_CTRL_RESET[UMP_BIT_MCE:UMP_BIT_RI]});
			txState_ff <= UMP_S_IDLE;
			rxState_ff <= UMP_S_IDLE;
			txShift_ff <= 8'h00;
			txCount_ff <= 4'h0;
			txPin_ff <= UMP_LINE_IDLE;
			rxShift_ff <= 8'h00;
			rxCount_ff <= 4'h0;
			rxNinth_ff <= 1'b0;
			rxLatch_ff <= 8'h00;
			rxPrev_ff <= UMP_LINE_IDLE;
			rdData_ff <= 8'h00;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
			txState_ff <= nxt_txState;
			rxState_ff <= nxt_rxState;
			txShift_ff <= nxt_txShift;
			txCount_ff <= nxt_txCount;
			txPin_ff <= nxt_txPin;
			rxShift_ff <= nxt_rxShift;
			rxCount_ff <= nxt_rxCount;
			rxNinth_ff <= nxt_rxNinth;
			rxLatch_ff <= nxt_rxLatch;
			rxPrev_ff <= serialRxPin;
			rdData_ff <= nxt_rdData;
		end
	end

	assign serialTxPin = txPin_ff;
	assign sfrRdData = rdData_ff;
	assign irqRequest = ctrl_ff.txDoneFlag || ctrl_ff.rxDoneFlag;
endmodule // ump_serial_port
